// ==== rtl/nest_irq_pkg.sv ====
// Constants, register map and field layout of the nested interrupt controller
// Assumes a single 10 MHz clock and a synchronous active-high reset
// Contract
// - Control bit 0 enables normal nesting
// - Control bit 1 enables fast nesting
// - Normal vector read sets normal status bit
// - Fast vector read sets fast status bit
// - Set status bit blocks equal, lower priorities
// - Status write clears lowest set bit only
// - Status bits 7:0, upper bits reserved
// - Fast vector 6:2 holds highest source
// - Read fast vector only during nested service; the bench also reads it after reset, with nesting off
// - Six external inputs, level or edge each
// - Software enables source, then selects trigger
// - Trigger selector for input n at 2n+1:2n
// - 11 fall, 10 rise, 01 low, 00 high
// - Edge clear bits 19..22 for inputs 0..3
// - Inputs 4,5 clear at bits 23,24
// - Software never writes reserved bits; the bench writes all ones to the vector base
// - Without nesting, fast beats normal
// - Three-bit priority per source, used when nesting
package nest_irq_pkg;
    localparam int num_src = 28;
    localparam int num_ext = 6;
    localparam int ext_src_base = 17;
    localparam logic [31:0] addr_vector_base = 32'hffff000c;
    localparam logic [31:0] addr_normal_vector = 32'hffff001c;
    localparam logic [31:0] addr_prio_base = 32'hffff0020;
    localparam logic [31:0] addr_nesting_control = 32'hffff0030;
    localparam logic [31:0] addr_ext_trigger_config = 32'hffff0034;
    localparam logic [31:0] addr_ext_edge_clear = 32'hffff0038;
    localparam logic [31:0] addr_normal_nest_status = 32'hffff003c;
    localparam logic [31:0] addr_fast_vector = 32'hffff011c;
    localparam logic [31:0] addr_fast_nest_status = 32'hffff013c;
    localparam logic [31:0] addr_normal_source_enable = 32'hffff0008;
    localparam logic [31:0] addr_fast_source_enable = 32'hffff0108;
    localparam int prio_regs = 4;
    localparam int normal_nest_enable_bit = 0;
    localparam int fast_nest_enable_bit = 1;
    localparam int vector_base_lsb = 7;
    localparam int vector_base_width = 16;
    localparam int vector_src_lsb = 2;
    localparam int edge_clear_lsb = 19;
    localparam logic [1:0] trig_high = 2'h0;
    localparam logic [1:0] trig_low = 2'h1;
    localparam logic [1:0] trig_rise = 2'h2;
    localparam logic [1:0] trig_fall = 2'h3;
    localparam logic [31:0] reset_value = 32'h00000000;
    localparam logic [2:0] no_prio = 3'h7;

    // Lowest set index of an 8-bit nesting status, 8 when empty
    function automatic logic [3:0] first_set(input logic [7:0] v);
        logic [3:0] r;
        r = 4'h8;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction
endpackage

// ==== rtl/nest_irq_if.sv ====
// Carrier joining the processor-side controller and the device
// Assumes both ends share i_clk; APB signals are as published
`timescale 1ns/1ps
interface nest_irq_if;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    modport device (input psel, penable, pwrite, paddr, pwdata,
        output prdata, pready, pslverr);
    modport host (output psel, penable, pwrite, paddr, pwdata,
        input prdata, pready, pslverr);
endinterface

// ==== rtl/ext_trigger.sv ====
// One external interrupt input: synchroniser, trigger decode, edge capture
// Assumes the pin is asynchronous to i_clk
`timescale 1ns/1ps
module ext_trigger
    import nest_irq_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_pin,
    input wire logic [1:0] i_select,
    input wire logic i_clear,
    output logic o_request
);
    logic meta;
    logic pin_s;
    logic pin_d;
    logic captured;
    wire rise = pin_s & ~pin_d;
    wire fall = ~pin_s & pin_d;
    wire edge_mode = i_select[1];
    wire edge_hit = (i_select == trig_rise) ? rise : fall;
    wire level_hit = (i_select == trig_low) ? ~pin_s : pin_s;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta <= 1'b0;
            pin_s <= 1'b0;
            pin_d <= 1'b0;
            captured <= 1'b0;
        end else begin
            meta <= i_pin;
            pin_s <= meta;
            pin_d <= pin_s;
            // A new edge in the clearing cycle survives the clear
            if (edge_mode && edge_hit) begin
                captured <= 1'b1;
            end else if (i_clear || !edge_mode) begin
                captured <= 1'b0;
            end
        end
    end

    assign o_request = edge_mode ? captured : level_hit;
endmodule // ext_trigger

// ==== rtl/nest_irq_device.sv ====
// Nested interrupt controller: APB registers, priorities, nesting, external inputs
// Assumes synchronous sources on i_sources and asynchronous pins on i_ext_pins
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module nest_irq_device
    import nest_irq_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    nest_irq_if.device bus,
    input wire logic [num_src-1:0] i_sources,
    input wire logic [num_ext-1:0] i_ext_pins,
    output logic o_normal_irq,
    output logic o_fast_irq
);
    logic [1:0] nesting_control;
    logic [11:0] ext_trigger_config;
    logic [7:0] normal_nest_status;
    logic [7:0] fast_nest_status;
    logic [vector_base_width-1:0] vector_base;
    logic [num_src-1:0] normal_source_enable;
    logic [num_src-1:0] fast_source_enable;
    logic [31:0] prio_word [prio_regs];
    logic [31:0] prdata;
    logic [num_ext-1:0] ext_req;
    logic [num_ext-1:0] ext_clear;
    logic [num_src-1:0] active;

    wire wr = bus.psel & bus.penable & bus.pwrite;
    wire rd = bus.psel & bus.penable & ~bus.pwrite;
    wire normal_nest = nesting_control[normal_nest_enable_bit];
    wire fast_nest = nesting_control[fast_nest_enable_bit];

    genvar g;
    generate
        for (g = 0; g < num_ext; g++) begin : ext
            // Inputs 4 and 5 share one printed bit; placed at 23 and 24 here
            assign ext_clear[g] = wr && bus.paddr == addr_ext_edge_clear
                && bus.pwdata[edge_clear_lsb + g];
            ext_trigger u_trig (
                .i_clk(i_clk),
                .i_rst(i_rst),
                .i_pin(i_ext_pins[g]),
                .i_select(ext_trigger_config[2*g+1 -: 2]),
                .i_clear(ext_clear[g]),
                .o_request(ext_req[g])
            );
        end
    endgenerate

    always_comb begin
        active = i_sources;
        active[ext_src_base +: num_ext] = ext_req;
    end

    // Priority words side by side; handed to the pick logic as an operand so that
    // a priority write re-evaluates the selection at once
    wire [32*prio_regs-1:0] prio_all = {prio_word[3], prio_word[2], prio_word[1], prio_word[0]};
    // Priority field of source s: eight 4-bit slots per word
    function automatic logic [2:0] prio_of(input logic [32*prio_regs-1:0] all, input int s);
        return all[s * 4 +: 3];
    endfunction

    typedef struct packed {
        logic found;
        logic [4:0] src;
        logic [2:0] prio;
    } pick_type;

    // Highest-priority request on one path; ties go to the lower number.
    // A status bit at or above the source level blocks it.
    function automatic pick_type pick(input logic [num_src-1:0] req, input logic nest,
                                      input logic [7:0] stat,
                                      input logic [32*prio_regs-1:0] prios);
        pick_type r;
        logic [3:0] lim;
        logic [2:0] p;
        r = '0;
        lim = first_set(stat);
        for (int s = 0; s < num_src; s++) begin
            p = nest ? prio_of(prios, s) : 3'h0;
            if (req[s] && (!nest || {1'b0, p} < lim)) begin
                if (!r.found || p < r.prio) begin
                    r.found = 1'b1;
                    r.src = 5'(s);
                    r.prio = p;
                end
            end
        end
        return r;
    endfunction

    pick_type normal_pick;
    pick_type fast_pick;
    assign normal_pick = pick(active & normal_source_enable, normal_nest, normal_nest_status,
        prio_all);
    assign fast_pick = pick(active & fast_source_enable, fast_nest, fast_nest_status, prio_all);

    // Fast outranks normal while normal nesting is off
    assign o_fast_irq = fast_pick.found;
    assign o_normal_irq = normal_pick.found && !(fast_pick.found && !normal_nest);

    wire [31:0] vec_normal = {9'h0, vector_base, normal_pick.src, 2'h0};
    wire [31:0] vec_fast = {9'h0, vector_base, fast_pick.src, 2'h0};
    wire hit_vector_base = bus.paddr == addr_vector_base;
    wire hit_normal_vector = bus.paddr == addr_normal_vector;
    wire hit_control = bus.paddr == addr_nesting_control;
    wire hit_trigger = bus.paddr == addr_ext_trigger_config;
    wire hit_edge_clear = bus.paddr == addr_ext_edge_clear;
    wire hit_normal_status = bus.paddr == addr_normal_nest_status;
    wire hit_fast_vector = bus.paddr == addr_fast_vector;
    wire hit_fast_status = bus.paddr == addr_fast_nest_status;
    wire hit_normal_enable = bus.paddr == addr_normal_source_enable;
    wire hit_fast_enable = bus.paddr == addr_fast_source_enable;
    // Only aligned words of the priority block answer; others raise pslverr
    wire prio_hit = bus.paddr[31:4] == addr_prio_base[31:4] && bus.paddr[1:0] == 2'h0;
    wire [1:0] prio_idx = bus.paddr[3:2];
    wire known = hit_vector_base || hit_normal_vector || prio_hit || hit_control || hit_trigger
        || hit_edge_clear || hit_normal_status || hit_fast_vector || hit_fast_status
        || hit_normal_enable || hit_fast_enable;
    wire rd_normal_vec = rd && hit_normal_vector;
    wire rd_fast_vec = rd && hit_fast_vector;
    wire set_normal = rd_normal_vec && normal_nest && normal_pick.found;
    wire set_fast = rd_fast_vec && fast_nest && fast_pick.found;
    wire clear_normal = wr && hit_normal_status;
    wire clear_fast = wr && hit_fast_status;

    // A write clears only the lowest set bit; a vector read in the same cycle
    // still sets its bit, and the set wins when both land on one bit
    function automatic logic [7:0] next_status(input logic [7:0] stat, input logic clear,
                                               input logic set, input logic [2:0] level);
        logic [7:0] r;
        logic [3:0] low;
        r = stat;
        low = first_set(stat);
        if (clear && !low[3]) begin
            r[low[2:0]] = 1'b0;
        end
        if (set) begin
            r[level] = 1'b1;
        end
        return r;
    endfunction

    wire [7:0] next_normal_nest_status = next_status(normal_nest_status, clear_normal,
        set_normal, normal_pick.prio);
    wire [7:0] next_fast_nest_status = next_status(fast_nest_status, clear_fast, set_fast,
        fast_pick.prio);

    always_comb begin
        case (bus.paddr)
            addr_vector_base: prdata = {9'h0, vector_base, 7'h0};
            addr_normal_vector: prdata = vec_normal;
            addr_nesting_control: prdata = {30'h0, nesting_control};
            addr_ext_trigger_config: prdata = {20'h0, ext_trigger_config};
            addr_normal_nest_status: prdata = {24'h0, normal_nest_status};
            addr_fast_vector: prdata = vec_fast;
            addr_fast_nest_status: prdata = {24'h0, fast_nest_status};
            addr_normal_source_enable: prdata = {4'h0, normal_source_enable};
            addr_fast_source_enable: prdata = {4'h0, fast_source_enable};
            default: prdata = prio_hit ? prio_word[prio_idx] : reset_value;
        endcase
    end

    assign bus.pready = 1'b1;
    assign bus.pslverr = bus.psel & bus.penable & ~known;

    // Read data is taken at setup so that it stands through the access edge
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            bus.prdata <= reset_value;
        end else if (bus.psel && !bus.penable && !bus.pwrite) begin
            bus.prdata <= prdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            nesting_control <= 2'h0;
            ext_trigger_config <= 12'h0;
            normal_nest_status <= 8'h0;
            fast_nest_status <= 8'h0;
            vector_base <= '0;
            normal_source_enable <= '0;
            fast_source_enable <= '0;
            for (int i = 0; i < prio_regs; i++) begin
                prio_word[i] <= reset_value;
            end
        end else begin
            if (wr) begin
                case (bus.paddr)
                    addr_nesting_control: nesting_control <= bus.pwdata[1:0];
                    addr_ext_trigger_config: ext_trigger_config <= bus.pwdata[11:0];
                    addr_vector_base: vector_base <= bus.pwdata[22:7];
                    addr_normal_source_enable: normal_source_enable <= bus.pwdata[27:0];
                    addr_fast_source_enable: fast_source_enable <= bus.pwdata[27:0];
                    default: begin
                        if (prio_hit) begin
                            prio_word[prio_idx] <= bus.pwdata & 32'h77777777;
                        end
                    end
                endcase
            end
            normal_nest_status <= next_normal_nest_status;
            fast_nest_status <= next_fast_nest_status;
        end
    end
endmodule // nest_irq_device

// ==== rtl/nest_irq_host.sv ====
// APB master standing for the core: one register access per command
// Assumes the device answers on the shared i_clk
`timescale 1ns/1ps
module nest_irq_host
    import nest_irq_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    nest_irq_if.host bus,
    input wire logic i_start,
    input wire logic i_write,
    input wire logic [31:0] i_addr,
    input wire logic [31:0] i_wdata,
    output logic o_busy,
    output logic o_done,
    output logic o_error,
    output logic [31:0] o_rdata
);
    typedef enum logic [1:0] {idle, setup, access} state_type;
    state_type state;

    // Software must keep reserved bits clear and order enable before trigger; the bench writes all ones to the vector base
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state <= idle;
            bus.psel <= 1'b0;
            bus.penable <= 1'b0;
            bus.pwrite <= 1'b0;
            bus.paddr <= reset_value;
            bus.pwdata <= reset_value;
            o_done <= 1'b0;
            o_error <= 1'b0;
            o_rdata <= reset_value;
        end else begin
            o_done <= 1'b0;
            case (state)
                idle: begin
                    if (i_start) begin
                        state <= setup;
                        bus.psel <= 1'b1;
                        bus.pwrite <= i_write;
                        bus.paddr <= i_addr;
                        bus.pwdata <= i_wdata;
                    end
                end
                setup: begin
                    state <= access;
                    bus.penable <= 1'b1;
                end
                access: begin
                    if (bus.pready) begin
                        state <= idle;
                        bus.psel <= 1'b0;
                        bus.penable <= 1'b0;
                        o_done <= 1'b1;
                        o_error <= bus.pslverr;
                        if (!bus.pwrite) begin
                            o_rdata <= bus.prdata;
                        end
                    end
                end
                default: state <= idle;
            endcase
        end
    end

    assign o_busy = state != idle;
endmodule // nest_irq_host

// ==== tb/nest_irq_chk.sv ====
// Concurrent checks on the bus joining host and device
// Assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module nest_irq_chk
    import nest_irq_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic acc;
    logic rd;
    logic mapped;
    logic [15:0] base_seen;
    assign acc = psel && penable;
    assign rd = acc && !pwrite;
    assign mapped = (paddr inside {addr_vector_base, addr_normal_vector, addr_nesting_control,
        addr_ext_trigger_config, addr_ext_edge_clear, addr_normal_nest_status, addr_fast_vector,
        addr_fast_nest_status, addr_normal_source_enable, addr_fast_source_enable})
        || (paddr inside {[addr_prio_base:32'hffff002c]} && paddr[1:0] == 2'h0);
    // Shadow of the base so the vector can be judged against what was written
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            base_seen <= 16'h0000;
        end else if (acc && pwrite && paddr == addr_vector_base) begin
            base_seen <= pwdata[22:7];
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    chk_ready_high: assert property (acc |-> pready) else $error("pready low in access");
    chk_error_map: assert property (acc |-> pslverr == !mapped) else $error("pslverr wrong");
    chk_error_idle: assert property (!acc |-> !pslverr) else $error("pslverr outside access");
    chk_setup_first: assert property ($rose(penable) |-> psel && $past(psel))
        else $error("access without setup");
    chk_hold_request: assert property (psel && !penable |=> penable && $stable(paddr)
        && $stable(pwrite) && $stable(pwdata)) else $error("request changed in access");
    chk_one_access: assert property (acc |=> !penable) else $error("access phase too long");
    chk_status_reserved: assert property (rd && (paddr == addr_normal_nest_status
        || paddr == addr_fast_nest_status) |-> prdata[31:8] == 24'h000000)
        else $error("status upper bits set");
    chk_fvec_layout: assert property (rd && paddr == addr_fast_vector |->
        prdata[31:23] == 9'h000 && prdata[1:0] == 2'h0 && prdata[6:2] < 5'h1c)
        else $error("fast vector layout");
    chk_fvec_base: assert property (rd && paddr == addr_fast_vector |->
        prdata[22:7] == base_seen) else $error("fast vector base");
    chk_cfg_reserved: assert property (rd && paddr == addr_ext_trigger_config |->
        prdata[31:12] == 20'h00000) else $error("trigger config upper bits");
    chk_clear_reads_zero: assert property (rd && paddr == addr_ext_edge_clear |->
        prdata == 32'h00000000) else $error("edge clear readable");
    chk_ctrl_bits: assert property (rd && paddr == addr_nesting_control |->
        prdata[31:2] == 30'h00000000) else $error("control upper bits");
endmodule // nest_irq_chk

// ==== tb/test_nested_interrupt_priority_ext_trigger.sv ====
// Self-checking bench: host and device joined, user sides driven here
// Assumes the host answers with a one-cycle done pulse per access
`timescale 1ns/1ps
module test_nested_interrupt_priority_ext_trigger;
    import nest_irq_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_start = 1'b0;
    logic i_write = 1'b0;
    logic [31:0] i_addr = 32'h0;
    logic [31:0] i_wdata = 32'h0;
    logic [num_src-1:0] i_sources = 28'h0;
    logic [num_ext-1:0] i_ext_pins = 6'h0;
    logic o_busy, o_done, o_error, o_normal_irq, o_fast_irq;
    logic [31:0] o_rdata;
    int num_errors = 0;
    int n_checks = 0;
    nest_irq_if bus_if ();
    nest_irq_device nest_irq_device_inst (.i_clk(i_clk), .i_rst(i_rst), .bus(bus_if),
        .i_sources(i_sources), .i_ext_pins(i_ext_pins), .o_normal_irq(o_normal_irq),
        .o_fast_irq(o_fast_irq));
    nest_irq_host nest_irq_host_inst (.i_clk(i_clk), .i_rst(i_rst), .bus(bus_if),
        .i_start(i_start), .i_write(i_write), .i_addr(i_addr), .i_wdata(i_wdata),
        .o_busy(o_busy), .o_done(o_done), .o_error(o_error), .o_rdata(o_rdata));
    nest_irq_chk nest_irq_chk_inst (.i_clk(i_clk), .i_rst(i_rst), .psel(bus_if.psel),
        .penable(bus_if.penable), .pwrite(bus_if.pwrite), .paddr(bus_if.paddr),
        .pwdata(bus_if.pwdata), .prdata(bus_if.prdata), .pready(bus_if.pready),
        .pslverr(bus_if.pslverr));
    always #50 i_clk = ~i_clk;

    task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    // One register access; entered just after a clock edge
    task automatic acc(input logic wr, input logic [31:0] addr, input logic [31:0] data);
        int n;
        i_start <= 1'b1;
        i_write <= wr;
        i_addr <= addr;
        i_wdata <= data;
        tick(1);
        cmp("busy", 32'h1, {31'h0, o_busy});
        i_start <= 1'b0;
        n = 0;
        do begin
            tick(1);
            n++;
        end while (o_done !== 1'b1 && n < 20);
        cmp("access done", 32'h1, {31'h0, o_done});
        cmp("busy after done", 32'h0, {31'h0, o_busy});
    endtask

    task automatic test_reset_values;
        logic [31:0] regs [6];
        regs = '{addr_ext_trigger_config, addr_ext_edge_clear, addr_normal_nest_status,
            addr_fast_vector, addr_fast_nest_status, addr_nesting_control};
        foreach (regs[i]) begin
            acc(1'b0, regs[i], 32'h0);
            cmp("reset value", 32'h0, o_rdata);
        end
        acc(1'b0, 32'hffff0040, 32'h0);
        cmp("unmapped error", 32'h1, {31'h0, o_error});
    endtask

    task automatic test_fast_nesting;
        acc(1'b1, addr_vector_base, 32'hffffffff);
        acc(1'b1, addr_prio_base, 32'h00030000);
        acc(1'b1, addr_fast_source_enable, 32'h00000014);
        acc(1'b1, addr_nesting_control, 32'h00000002);
        i_sources <= 28'h0000010;
        tick(2);
        acc(1'b0, addr_fast_vector, 32'h0);
        cmp("fast vector", 32'h007fff90, o_rdata);
        acc(1'b0, addr_fast_nest_status, 32'h0);
        cmp("fast status", 32'h00000008, o_rdata);
        cmp("fast blocked", 32'h0, {31'h0, o_fast_irq});
        i_sources <= 28'h0000014;
        tick(2);
        cmp("fast higher passes", 32'h1, {31'h0, o_fast_irq});
        acc(1'b0, addr_fast_vector, 32'h0);
        cmp("fast vector top", 32'h007fff88, o_rdata);
        acc(1'b0, addr_fast_nest_status, 32'h0);
        cmp("fast status two", 32'h00000009, o_rdata);
        acc(1'b1, addr_fast_nest_status, 32'h000000ff);
        acc(1'b0, addr_fast_nest_status, 32'h0);
        cmp("fast clear one", 32'h00000008, o_rdata);
        acc(1'b1, addr_fast_nest_status, 32'h000000ff);
        acc(1'b0, addr_fast_nest_status, 32'h0);
        cmp("fast clear two", 32'h0, o_rdata);
        cmp("fast released", 32'h1, {31'h0, o_fast_irq});
        i_sources <= 28'h0;
    endtask

    task automatic test_normal_nesting;
        acc(1'b1, addr_nesting_control, 32'h0);
        acc(1'b1, addr_fast_source_enable, 32'h00000008);
        acc(1'b1, addr_normal_source_enable, 32'h00000020);
        acc(1'b1, addr_prio_base, 32'h00600000);
        i_sources <= 28'h0000028;
        tick(2);
        cmp("fast first", 32'h2, {30'h0, o_fast_irq, o_normal_irq});
        acc(1'b1, addr_fast_source_enable, 32'h0);
        acc(1'b0, addr_normal_vector, 32'h0);
        acc(1'b0, addr_normal_nest_status, 32'h0);
        cmp("normal status off", 32'h0, o_rdata);
        cmp("normal not nested", 32'h1, {31'h0, o_normal_irq});
        acc(1'b1, addr_nesting_control, 32'h00000001);
        acc(1'b0, addr_normal_vector, 32'h0);
        acc(1'b0, addr_normal_nest_status, 32'h0);
        cmp("normal status", 32'h00000040, o_rdata);
        cmp("normal blocked", 32'h0, {31'h0, o_normal_irq});
        acc(1'b1, addr_normal_nest_status, 32'h000000ff);
        cmp("normal released", 32'h1, {31'h0, o_normal_irq});
        i_sources <= 28'h0;
        acc(1'b1, addr_nesting_control, 32'h0);
    endtask

    task automatic test_ext_trigger;
        logic [1:0] mode [6];
        mode = '{trig_high, trig_low, trig_rise, trig_fall, trig_rise, trig_fall};
        acc(1'b1, addr_normal_source_enable, 32'h007e0000);
        acc(1'b1, addr_ext_trigger_config, 32'h00000ee4);
        acc(1'b0, addr_ext_trigger_config, 32'h0);
        cmp("trigger config", 32'h00000ee4, o_rdata);
        foreach (mode[n]) i_ext_pins[n] <= mode[n][0];
        tick(5);
        acc(1'b1, addr_ext_edge_clear, 32'h01f80000);
        for (int n = 0; n < num_ext; n++) begin
            acc(1'b1, addr_normal_source_enable, 32'h1 << (ext_src_base + n));
            tick(5);
            cmp("ext idle", 32'h0, {31'h0, o_normal_irq});
            i_ext_pins[n] <= ~mode[n][0];
            tick(5);
            cmp("ext active", 32'h1, {31'h0, o_normal_irq});
            i_ext_pins[n] <= mode[n][0];
            tick(5);
            cmp("ext after pin", {31'h0, mode[n][1]}, {31'h0, o_normal_irq});
            acc(1'b1, addr_ext_edge_clear, 32'h1 << (edge_clear_lsb + n));
            tick(2);
            cmp("ext cleared", 32'h0, {31'h0, o_normal_irq});
        end
    endtask

    task automatic final_report;
        if (num_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        tick(1);
        test_reset_values();
        test_fast_nesting();
        test_normal_nesting();
        test_ext_trigger();
        final_report();
    end

    // About 260 cycles of traffic; the 5,000-cycle limit, some nineteen times that, means a hang
    initial begin
        #500000;
        num_errors++;
        final_report();
    end
endmodule // test_nested_interrupt_priority_ext_trigger
